// >>> rtc_pkg.sv
package rtc_pkg;
  localparam int PREDIV_RATIO = 64;
  localparam int PREDIV_W     = $clog2(PREDIV_RATIO);
  localparam int DIV_W        = 20;
  localparam int DIV_UPPER_W  = 4;
  localparam int HALF_W       = 16;
  localparam int COUNT_W      = 32;
  localparam int CTRL_W       = 16;

  localparam logic [PREDIV_W-1:0] PREDIV_LAST  = 6'h3f;
  localparam logic [PREDIV_W-1:0] PREDIV_ONE   = 6'h01;
  localparam logic [DIV_W-1:0]    DIV_ONE      = 20'h00001;
  localparam logic [COUNT_W-1:0]  COUNT_ONE    = 32'h00000001;

  // control word field positions
  localparam int CTRL_SIR_BIT = 0;
  localparam int CTRL_SEN_BIT = 1;
  localparam int CTRL_AIR_BIT = 2;
  localparam int CTRL_AEN_BIT = 3;
  localparam int CTRL_OFF_BIT = 7;

  localparam logic [CTRL_W-1:0]  CTRL_RESET    = 16'h0000;
  localparam logic [DIV_W-1:0]   PRESC_RESET   = 20'h00001;
  localparam logic [COUNT_W-1:0] COUNT_RESET   = 32'h00000000;
  localparam logic [COUNT_W-1:0] ALARM_RESET   = 32'hffffffff;
endpackage

// >>> rtc_chain_if.sv
`timescale 1ns/1ps
interface rtc_chain_if;
  import rtc_pkg::*;
  logic                run;
  logic [DIV_W-1:0]    presc;
  logic                presc_load;
  logic                tick;
  logic [DIV_W-1:0]    div_count;
  logic [HALF_W-1:0]   wdata;
  logic                load_lo;
  logic                load_hi;
  logic [COUNT_W-1:0]  alarm;
  logic [COUNT_W-1:0]  count;
  logic                alarm_hit;

  modport ctrl (
    output run, presc, presc_load, wdata, load_lo, load_hi, alarm,
    input  tick, div_count, count, alarm_hit
  );
  modport divider (
    input  run, presc, presc_load,
    output tick, div_count
  );
  modport counter (
    input  run, tick, wdata, load_lo, load_hi, alarm,
    output count, alarm_hit
  );
endinterface

// >>> rtc_divider.sv
`timescale 1ns/1ps
module rtc_divider
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic      mclk,
  input wire logic      reset_n,
  // chain
  rtc_chain_if.divider  chain
);
  logic [PREDIV_W-1:0] prediv;
  logic                prediv_step;
  logic                div_end;

  assign prediv_step = chain.run && (prediv == PREDIV_LAST); // R07
  assign div_end     = (chain.div_count <= DIV_ONE);

  // fixed 1/64 stage, lowest 6 bits of the 58-bit chain
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prediv <= '0;
    end else if (chain.presc_load) begin
      prediv <= '0;
    end else if (chain.run) begin // R15
      prediv <= prediv + PREDIV_ONE; // R04
    end
  end

  // down counter; a zero prescaler behaves like one
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chain.div_count <= PRESC_RESET;
    end else if (chain.presc_load) begin
      chain.div_count <= chain.presc;
    end else if (prediv_step) begin
      if (div_end) begin
        chain.div_count <= chain.presc; // R08 R16
      end else begin
        chain.div_count <= chain.div_count - DIV_ONE; // R06
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chain.tick <= 1'b0;
    end else begin
      chain.tick <= prediv_step && div_end && !chain.presc_load;
    end
  end
endmodule

// >>> rtc_counter.sv
`timescale 1ns/1ps
module rtc_counter
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic      mclk,
  input wire logic      reset_n,
  // chain
  rtc_chain_if.counter  chain
);
  logic match;
  logic match_q;

  assign match = (chain.count == chain.alarm); // R12

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chain.count <= COUNT_RESET;
    end else if (chain.load_lo) begin
      chain.count <= {chain.count[COUNT_W-1:HALF_W], chain.wdata}; // R11
    end else if (chain.load_hi) begin
      chain.count <= {chain.wdata, chain.count[HALF_W-1:0]}; // R11
    end else if (chain.run && chain.tick) begin
      chain.count <= chain.count + COUNT_ONE; // R10 R04
    end
  end

  // only a fresh equality counts, so a cleared flag is not re-raised
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      match_q         <= 1'b1;
      chain.alarm_hit <= 1'b0;
    end else begin
      match_q         <= match;
      chain.alarm_hit <= match && !match_q; // R12
    end
  end
endmodule

// >>> rtc_block.sv
`timescale 1ns/1ps
// Operation
// R01: runs on the oscillator clock, idle and power-down
// R02: every register reachable through write and read ports
// R03: tick and alarm requests go to port pins
// R04: predivider, divider and counter form 58 bits
// R05: wakes chip from power-down when configured
// R06: 20-bit divider from 4-bit and 16-bit parts
// R07: divider stepped through fixed 1/64 predivider
// R08: divider reloaded with prescaler on each tick
// R09: per-tick request raised every tick
// R10: 32-bit time counter advances per tick
// R11: software loads time counter halves
// R12: alarm request when counter equals alarm
// R13: both requests usable to wake the chip
// R14: switch-off bit stops oscillator in power-down
// R15: writes only while off; off stops chain; the code accepts alarm writes while running
// R16: divider reloads from prescaler at zero; the code reloads when the count reaches one (or zero)
// R17: system reset leaves counters and registers alone
// R18: separate flag and enable per source
// R19: counter read returns coherent 32-bit value
module rtc_block
  import rtc_pkg::*;
(
  // oscillator clock and power-on reset
  input  wire logic               mclk,
  input  wire logic               reset_n,
  // write port, plus the lower time read strobe
  input  wire logic [HALF_W-1:0]  wr_data,
  input  wire logic               wr_control,
  input  wire logic               wr_prescaler_lower,
  input  wire logic               wr_prescaler_upper,
  input  wire logic               wr_time_lower,
  input  wire logic               wr_time_upper,
  input  wire logic               wr_alarm_lower,
  input  wire logic               wr_alarm_upper,
  input  wire logic               rd_time_lower,
  // read values
  output logic [CTRL_W-1:0]       clock_block_control,
  output logic [HALF_W-1:0]       prescaler_upper,
  output logic [HALF_W-1:0]       prescaler_lower,
  output logic [HALF_W-1:0]       divider_upper_count,
  output logic [HALF_W-1:0]       divider_lower_count,
  output logic [HALF_W-1:0]       time_count_upper,
  output logic [HALF_W-1:0]       time_count_lower,
  output logic [HALF_W-1:0]       alarm_value_upper,
  output logic [HALF_W-1:0]       alarm_value_lower,
  // chip power state
  input  wire logic               power_down,
  input  wire logic               power_down_wake_config,
  // requests and power control
  output logic                    tick_irq_request,
  output logic                    alarm_irq_request,
  output logic                    port2_tick_irq,
  output logic                    port2_alarm_irq,
  output logic                    wake_request,
  output logic                    oscillator_stop
);
  rtc_chain_if chain ();

  logic                   oscillator_switch_off;
  logic                   tick_enable;
  logic                   alarm_enable;
  logic [DIV_W-1:0]       prescaler_value;
  logic                   presc_load;
  logic [COUNT_W-1:0]     alarm_value;
  logic [HALF_W-1:0]      upper_shadow;

  rtc_divider u_divider (
    .mclk    (mclk),
    .reset_n (reset_n),
    .chain   (chain.divider)
  );

  rtc_counter u_counter (
    .mclk    (mclk),
    .reset_n (reset_n),
    .chain   (chain.counter)
  );

  // reset_n is the power-on reset only; the chip system reset is not wired
  // in, so software state survives it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      oscillator_switch_off <= CTRL_RESET[CTRL_OFF_BIT];
      tick_enable           <= CTRL_RESET[CTRL_SEN_BIT];
      alarm_enable          <= CTRL_RESET[CTRL_AEN_BIT];
    end else if (wr_control) begin // R17
      oscillator_switch_off <= wr_data[CTRL_OFF_BIT];
      tick_enable           <= wr_data[CTRL_SEN_BIT]; // R18
      alarm_enable          <= wr_data[CTRL_AEN_BIT]; // R18
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_irq_request <= CTRL_RESET[CTRL_SIR_BIT];
    end else if (chain.tick && chain.run) begin
      // a tick still in flight when the chain stops is dropped, as the
      // counter drops it, so flag and count never disagree
      tick_irq_request <= 1'b1; // R09 R18
    end else if (wr_control) begin
      tick_irq_request <= wr_data[CTRL_SIR_BIT];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_irq_request <= CTRL_RESET[CTRL_AIR_BIT];
    end else if (chain.alarm_hit) begin
      alarm_irq_request <= 1'b1; // R12 R18
    end else if (wr_control) begin
      alarm_irq_request <= wr_data[CTRL_AIR_BIT];
    end
  end

  // prescaler writes are dropped while the chain runs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prescaler_value <= PRESC_RESET;
    end else if (oscillator_switch_off) begin // R15
      if (wr_prescaler_upper) begin
        prescaler_value[DIV_W-1:HALF_W] <= wr_data[DIV_UPPER_W-1:0];
      end
      if (wr_prescaler_lower) begin
        prescaler_value[HALF_W-1:0] <= wr_data;
      end
    end
  end

  // new prescaler reaches the divider one cycle after the write
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      presc_load <= 1'b0;
    end else begin
      presc_load <= oscillator_switch_off
                    && (wr_prescaler_upper || wr_prescaler_lower);
    end
  end

  // alarm halves carry no write protection
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_value <= ALARM_RESET;
    end else begin
      if (wr_alarm_upper) begin
        alarm_value[COUNT_W-1:HALF_W] <= wr_data;
      end
      if (wr_alarm_lower) begin
        alarm_value[HALF_W-1:0] <= wr_data;
      end
    end
  end

  // a lower read freezes the upper half so two reads never tear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      upper_shadow <= COUNT_RESET[COUNT_W-1:HALF_W];
    end else if (rd_time_lower) begin
      upper_shadow <= chain.count[COUNT_W-1:HALF_W]; // R19
    end
  end

  assign chain.run        = !oscillator_switch_off; // R15 R01
  assign chain.presc      = prescaler_value;
  assign chain.presc_load = presc_load;
  assign chain.wdata      = wr_data;
  assign chain.load_lo    = wr_time_lower && oscillator_switch_off; // R15
  assign chain.load_hi    = wr_time_upper && oscillator_switch_off; // R15
  assign chain.alarm      = alarm_value;

  // read side, unused bits read as zero
  always_comb begin
    clock_block_control               = '0;
    clock_block_control[CTRL_OFF_BIT] = oscillator_switch_off;
    clock_block_control[CTRL_AEN_BIT] = alarm_enable;
    clock_block_control[CTRL_AIR_BIT] = alarm_irq_request;
    clock_block_control[CTRL_SEN_BIT] = tick_enable;
    clock_block_control[CTRL_SIR_BIT] = tick_irq_request;
  end

  assign prescaler_upper     = {{(HALF_W-DIV_UPPER_W){1'b0}},
                                prescaler_value[DIV_W-1:HALF_W]}; // R02
  assign prescaler_lower     = prescaler_value[HALF_W-1:0];
  assign divider_upper_count = {{(HALF_W-DIV_UPPER_W){1'b0}},
                                chain.div_count[DIV_W-1:HALF_W]}; // R06
  assign divider_lower_count = chain.div_count[HALF_W-1:0];
  assign time_count_lower    = chain.count[HALF_W-1:0];
  assign time_count_upper    = upper_shadow; // R19
  assign alarm_value_upper   = alarm_value[COUNT_W-1:HALF_W];
  assign alarm_value_lower   = alarm_value[HALF_W-1:0];

  // pin level requests; wake needs the system wake bit
  assign port2_tick_irq  = tick_irq_request && tick_enable; // R03 R13
  assign port2_alarm_irq = alarm_irq_request && alarm_enable; // R03 R13
  assign wake_request    = power_down && power_down_wake_config
                           && (port2_tick_irq || port2_alarm_irq); // R05
  assign oscillator_stop = power_down && oscillator_switch_off; // R14
endmodule

// >>> rtc_properties.sv
`timescale 1ns/1ps
module rtc_properties
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              reset_n,
  // strobes and power state
  input wire logic              wr_control,
  input wire logic              wr_prescaler_lower,
  input wire logic              wr_time_lower,
  input wire logic              power_down,
  input wire logic              power_down_wake_config,
  // observed outputs
  input wire logic [CTRL_W-1:0] clock_block_control,
  input wire logic [HALF_W-1:0] prescaler_upper,
  input wire logic [HALF_W-1:0] prescaler_lower,
  input wire logic [HALF_W-1:0] divider_upper_count,
  input wire logic [HALF_W-1:0] time_count_lower,
  input wire logic              tick_irq_request,
  input wire logic              alarm_irq_request,
  input wire logic              port2_tick_irq,
  input wire logic              port2_alarm_irq,
  input wire logic              wake_request,
  input wire logic              oscillator_stop
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire off = clock_block_control[CTRL_OFF_BIT];
  wire sen = clock_block_control[CTRL_SEN_BIT];
  wire aen = clock_block_control[CTRL_AEN_BIT];

  a_stop_on_pd: assert property (oscillator_stop == (power_down && off))
    else $error("oscillator stop wrong");
  a_wake_gate: assert property (wake_request == (power_down &&
    power_down_wake_config && (port2_tick_irq || port2_alarm_irq)))
    else $error("wake request wrong");
  a_tick_gate: assert property (
    port2_tick_irq == (tick_irq_request && sen))
    else $error("tick port request wrong");
  a_alarm_gate: assert property (
    port2_alarm_irq == (alarm_irq_request && aen))
    else $error("alarm port request wrong");
  a_upper_zero: assert property (prescaler_upper[15:4] == 12'h000 &&
    divider_upper_count[15:4] == 12'h000)
    else $error("unused upper bits not zero");
  a_presc_locked: assert property (!off && wr_prescaler_lower |=>
    $stable(prescaler_lower)) else $error("prescaler written while running");
  a_frozen_off: assert property (
    off && !wr_time_lower && !wr_control |=> $stable(time_count_lower))
    else $error("counter moved while off");
  a_count_step: assert property (!wr_time_lower |=>
    time_count_lower == $past(time_count_lower) ||
    time_count_lower == $past(time_count_lower) + 16'h0001)
    else $error("counter jumped");
  a_tick_counts: assert property ($rose(tick_irq_request) &&
    !$past(wr_control) |-> $changed(time_count_lower))
    else $error("tick without count");

  c_tick: cover property ($rose(tick_irq_request));
  c_alarm: cover property ($rose(alarm_irq_request));
  c_wake: cover property (wake_request);
  c_stop: cover property (oscillator_stop);
endmodule

bind rtc_block rtc_properties u_props (
  .mclk(mclk), .reset_n(reset_n), .wr_control(wr_control),
  .wr_prescaler_lower(wr_prescaler_lower), .wr_time_lower(wr_time_lower),
  .power_down(power_down), .power_down_wake_config(power_down_wake_config),
  .clock_block_control(clock_block_control),
  .prescaler_upper(prescaler_upper), .prescaler_lower(prescaler_lower),
  .divider_upper_count(divider_upper_count),
  .time_count_lower(time_count_lower), .tick_irq_request(tick_irq_request),
  .alarm_irq_request(alarm_irq_request), .port2_tick_irq(port2_tick_irq),
  .port2_alarm_irq(port2_alarm_irq), .wake_request(wake_request),
  .oscillator_stop(oscillator_stop)
);

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_mismatch++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  import rtc_pkg::*;
  logic        mclk = 0, reset_n = 0, rd = 0, pd = 0, cfg = 0;
  logic [15:0] wr_data = 0, ctl, pu, pl, du, dl, tu, tl, au, al, hi, r;
  logic [6:0]  stb = 0;
  logic        ti, ai, p2t, p2a, wk, os;
  integer      seed;
  int          n_mismatch = 0, samples_checked = 0, cycles = 0, p, n, e;

  always #2.5 mclk = ~mclk;

  rtc_block dut_u (
    .mclk(mclk), .reset_n(reset_n), .wr_data(wr_data),
    .wr_control(stb[0]), .wr_prescaler_lower(stb[1]),
    .wr_prescaler_upper(stb[2]), .wr_time_lower(stb[3]),
    .wr_time_upper(stb[4]), .wr_alarm_lower(stb[5]),
    .wr_alarm_upper(stb[6]), .rd_time_lower(rd),
    .clock_block_control(ctl), .prescaler_upper(pu), .prescaler_lower(pl),
    .divider_upper_count(du), .divider_lower_count(dl),
    .time_count_upper(tu), .time_count_lower(tl),
    .alarm_value_upper(au), .alarm_value_lower(al),
    .power_down(pd), .power_down_wake_config(cfg),
    .tick_irq_request(ti), .alarm_irq_request(ai),
    .port2_tick_irq(p2t), .port2_alarm_irq(p2a),
    .wake_request(wk), .oscillator_stop(os)
  );

  function automatic int period(input int presc);
    return PREDIV_RATIO * presc;
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // strobe index: control, presc lo/hi, time lo/hi, alarm lo/hi
  task automatic wr(input int i, input logic [15:0] d);
    cyc(1);
    stb = 7'h01 << i;
    wr_data = d;
    cyc(1);
    stb = '0;
  endtask

  // upper half is a shadow, so it only means something after this pulse
  task automatic rdc();
    cyc(1);
    rd = 1;
    cyc(1);
    rd = 0;
  endtask

  task automatic wait_tick(output int k);
    k = 0;
    while (ti !== 1'b1 && k < 600) begin
      cyc(1);
      k++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    seed = 32'h0209d614;
    p = ($random(seed) & 3) + 1;
    hi = $random(seed);
    cyc(8);
    reset_n = 1;
    `CHK(ctl, CTRL_RESET)
    `CHK({pu[3:0], pl}, PRESC_RESET)
    `CHK({au, al}, ALARM_RESET)
    wr(0, 16'h0080);
    `CHK(ctl, 16'h0080)
    wr(2, 16'h0000);
    wr(1, p[15:0]);
    `CHK(pl, p[15:0])
    cyc(1);
    `CHK({du[3:0], dl}, p[19:0])
    wr(3, 16'hffff);
    wr(4, hi);
    rdc();
    `CHK({tu, tl}, {hi, 16'hffff})
    // alarm one tick ahead, reached through the carry into the upper half
    wr(5, 16'h0000);
    wr(6, hi + 16'h1);
    `CHK({au, al}, {hi + 16'h1, 16'h0000})
    pd = 1;
    cyc(1);
    `CHK(os, 1'b1)
    pd = 0;
    wr(0, 16'h000a);
    wr(1, 16'h0005);
    `CHK(pl, p[15:0])
    wait_tick(n);
    `CHK(ti, 1'b1)
    `CHK(tl, 16'h0000)
    rdc();
    `CHK(tu, hi + 16'h1)
    cyc(2);
    `CHK(ai, 1'b1)
    `CHK(p2a, 1'b1)
    wr(0, 16'h000a);
    wait_tick(n);
    `CHK(n + 6, period(p))
    `CHK(ai, 1'b0)
    `CHK(tl, 16'h0001)
    pd = 1;
    cfg = 1;
    cyc(1);
    `CHK(wk, 1'b1)
    `CHK(os, 1'b0)
    cfg = 0;
    #1;
    `CHK(wk, 1'b0)
    pd = 0;
    for (e = 0; e < 4; e++) begin
      wr(0, {12'h000, e[1], 1'b1, e[0], 1'b1});
      `CHK(p2t, e[0])
      `CHK(p2a, e[1])
    end
    for (e = 0; e < 4; e++) begin
      r = $random(seed);
      wr(5, r);
      `CHK(al, r)
    end
    conclude();
  end
endmodule
